// ### design/dsjd_params.svh
`ifndef DSJD_PARAMS_SVH
`define DSJD_PARAMS_SVH

// Opcode fields, upper six bits of a one-word decrement-and-skip instruction.
`define DSJD_OP_DSNZ      6'h13
`define DSJD_OP_DSZ       6'h0B
// Jump first word upper byte, second word upper nibble.
`define DSJD_OP_JMP_HI    8'hEF
`define DSJD_OP_JMP_LO    4'hF
// Bit positions inside a byte-oriented instruction word.
`define DSJD_BIT_DEST     9
`define DSJD_BIT_BANK     8
// Highest register address that goes through indexed literal offset mode.
`define DSJD_IDX_LIMIT    8'h5F
// Quarters per instruction cycle.
`define DSJD_QUARTERS     4
// Reset values.
`define DSJD_PC_RESET     21'h00000
`define DSJD_WREG_RESET   8'h00

`endif

// ### design/dsjd_pkg.sv
`default_nettype none
package dsjd_pkg;
	typedef enum logic [1:0] {
		DSJD_Q1 = 2'b00,
		DSJD_Q2 = 2'b01,
		DSJD_Q3 = 2'b10,
		DSJD_Q4 = 2'b11
	} dsjd_quarter_t;

	typedef enum logic [1:0] {
		DSJD_EXEC   = 2'b00,
		DSJD_SKIP   = 2'b01,
		DSJD_JMPNOP = 2'b10
	} dsjd_state_t;

	typedef enum logic [1:0] {
		DSJD_OP_NONE = 2'b00,
		DSJD_OP_DZ   = 2'b01,
		DSJD_OP_DNZ  = 2'b10,
		DSJD_OP_JMP  = 2'b11
	} dsjd_op_t;
endpackage
`default_nettype wire

// ### design/dsjd_quarter_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsjd_params.svh"

// Quarter-phase sequencer; the last quarter marks the instruction cycle boundary.
module dsjd_quarter_gen
	import dsjd_pkg::*;
(
	input  wire logic    clk,     // Core clock.
	input  wire logic    reset,   // Synchronous reset, active high.
	output dsjd_quarter_t quarter, // Current quarter phase.
	output logic          last_q   // High in the fourth quarter.
);
	logic [1:0] q_ff;

	always_ff @(posedge clk) begin
		if (reset) begin
			q_ff <= 2'h0;
		end else begin
			q_ff <= q_ff + 2'h1;
		end
	end

	assign quarter = dsjd_quarter_t'(q_ff);
	assign last_q  = (q_ff == 2'(`DSJD_QUARTERS - 1));
endmodule
`default_nettype wire

// ### design/dsjd_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsjd_params.svh"

// Operation
// - A word with top six bits 010011 is decrement-skip-if-nonzero with dest, bank and address.
// - Decrement-skip-if-nonzero writes register minus one to the working register if d is 0, else back.
// - A nonzero result of decrement-skip-if-nonzero discards the fetched next word as a no-op.
// - Bank bit 0 picks the quick access bank, 1 puts the bank select register on the upper address.
// - Bank bit 0 with extended set on and address at most 95 uses indexed literal offset addressing.
// - A skip lasts one, two, three or four cycles for no skip or a one, two or three word victim.
// - The first cycle decodes, reads, computes and writes in quarters one to four; skip cycles do nothing.
// - The jump is two words, upper byte 11101111 with target 7..0, then nibble 1111 with target 19..8.
// - The jump loads its 20-bit target into program counter bits 20 to 1 and changes no flag.
// - The jump takes exactly two cycles, the second a no-op while the pipeline refills.
// - Top six bits 001011 is decrement-skip-if-zero, which skips when the result is zero.
module dsjd_core
	import dsjd_pkg::*;
#(
	parameter int unsigned ADDR_W = 12
) (
	input  wire logic              clk,          // Core clock, 250 MHz.
	input  wire logic              reset,        // Synchronous reset, active high.
	input  wire logic [15:0]       instr_word,   // Fetched program word for this cycle.
	input  wire logic [1:0]        next_words,   // Length in words of the instruction after this one.
	input  wire logic              ext_set_en,   // Extended instruction set enabled.
	input  wire logic [3:0]        bank_sel,     // Bank select register value.
	input  wire logic [ADDR_W-1:0] idx_base,     // Index base for literal offset addressing.
	input  wire logic [7:0]        rf_rdata,     // Register file read data.
	output logic [ADDR_W-1:0]      rf_addr,      // Register file address.
	output logic                   rf_rd,        // Read strobe, one quarter.
	output logic                   rf_wr,        // Write strobe, one quarter.
	output logic [7:0]             rf_wdata,     // Register file write data.
	output logic [7:0]             wreg,         // Working register.
	output logic [20:0]            pc,           // Program counter, byte address.
	output logic                   nop_cycle,    // Current cycle is an inserted no-op.
	output logic [1:0]             quarter_out   // Quarter phase registered, one clock behind.
);
	dsjd_quarter_t quarter;
	logic          last_q;

	dsjd_quarter_gen u_qgen (
		.clk     (clk),
		.reset   (reset),
		.quarter (quarter),
		.last_q  (last_q)
	);

	function automatic dsjd_op_t decode_op(input logic [15:0] w);
		if (w[15:10] == `DSJD_OP_DSNZ)
			return DSJD_OP_DNZ;
		else if (w[15:10] == `DSJD_OP_DSZ)
			return DSJD_OP_DZ;
		else if (w[15:8] == `DSJD_OP_JMP_HI)
			return DSJD_OP_JMP;
		return DSJD_OP_NONE;
	endfunction

	dsjd_state_t   state_ff;
	logic [1:0]    skip_left_ff;
	dsjd_op_t      op_ff;
	logic [15:0]   word_ff;
	logic [7:0]    data_ff;
	logic [7:0]    result_ff;
	logic [7:0]    jmp_lo_ff;
	logic [ADDR_W-1:0] rf_addr_ff;
	logic          rf_rd_ff;
	logic          rf_wr_ff;
	logic [7:0]    rf_wdata_ff;
	logic [7:0]    wreg_ff;
	logic [20:0]   pc_ff;
	logic          nop_ff;
	logic [1:0]    quarter_ff;

	logic          executing;
	logic [7:0]    fa;
	dsjd_op_t      in_op;
	logic          in_dec;
	logic [7:0]    in_fa;
	logic [ADDR_W-1:0] nxt_rf_addr;
	logic          res_zero;
	logic          do_skip;

	assign executing = (state_ff == DSJD_EXEC);
	assign fa        = word_ff[7:0];
	assign in_op     = decode_op(instr_word);
	assign in_dec    = (in_op == DSJD_OP_DNZ) || (in_op == DSJD_OP_DZ);
	assign in_fa     = instr_word[7:0];
	assign res_zero  = (result_ff == 8'h00);
	assign do_skip   = (op_ff == DSJD_OP_DNZ) ? !res_zero :
			   (op_ff == DSJD_OP_DZ) ? res_zero : 1'b0;

	// The operand address is formed from the incoming word, so the read can stand in Q2.
	always_comb begin
		if (!instr_word[`DSJD_BIT_BANK] && ext_set_en && in_fa <= `DSJD_IDX_LIMIT)
			nxt_rf_addr = idx_base + ADDR_W'(in_fa);
		else if (!instr_word[`DSJD_BIT_BANK])
			nxt_rf_addr = ADDR_W'(in_fa[7] ? {4'hF, in_fa} : {4'h0, in_fa});
		else
			nxt_rf_addr = ADDR_W'({bank_sel, in_fa});
	end

	// Decode latches the word in Q1 of an executing cycle; skip cycles ignore the fetch.
	always_ff @(posedge clk) begin
		if (reset) begin
			op_ff   <= DSJD_OP_NONE;
			word_ff <= 16'h0000;
		end else if (quarter == DSJD_Q1 && executing) begin
			op_ff   <= in_op;
			word_ff <= instr_word;
		end
	end

	// Read in Q2, compute in Q3, write destination in Q4.
	always_ff @(posedge clk) begin
		if (reset) begin
			rf_addr_ff  <= '0;
			rf_rd_ff    <= 1'b0;
			rf_wr_ff    <= 1'b0;
			rf_wdata_ff <= 8'h00;
			data_ff     <= 8'h00;
			result_ff   <= 8'h00;
			wreg_ff     <= `DSJD_WREG_RESET;
			jmp_lo_ff   <= 8'h00;
		end else begin
			rf_rd_ff <= 1'b0;
			rf_wr_ff <= 1'b0;
			// In Q1 the latched op still belongs to the previous instruction.
			if (executing && quarter == DSJD_Q1 && in_dec) begin
				rf_addr_ff <= nxt_rf_addr;
				rf_rd_ff   <= 1'b1;
			end
			if (executing && (op_ff == DSJD_OP_DNZ || op_ff == DSJD_OP_DZ)) begin
				unique case (quarter)
					DSJD_Q1: begin
					end
					DSJD_Q2: data_ff <= rf_rdata;
					DSJD_Q3: result_ff <= data_ff - 8'h01;
					DSJD_Q4: begin
						if (word_ff[`DSJD_BIT_DEST]) begin
							rf_wr_ff    <= 1'b1;
							rf_wdata_ff <= result_ff;
						end else begin
							wreg_ff <= result_ff;
						end
					end
				endcase
			end
			if (executing && op_ff == DSJD_OP_JMP && quarter == DSJD_Q2)
				jmp_lo_ff <= word_ff[7:0];
		end
	end

	// Cycle sequencing, skip count and program counter.
	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff     <= DSJD_EXEC;
			skip_left_ff <= 2'h0;
			pc_ff        <= `DSJD_PC_RESET;
			nop_ff       <= 1'b0;
		end else if (last_q) begin
			unique case (state_ff)
				DSJD_EXEC: begin
					if (op_ff == DSJD_OP_JMP && instr_word[15:12] == `DSJD_OP_JMP_LO) begin
						pc_ff    <= {instr_word[11:0], jmp_lo_ff, 1'b0};
						state_ff <= DSJD_JMPNOP;
						nop_ff   <= 1'b1;
					end else if (do_skip) begin
						pc_ff        <= pc_ff + 21'h2;
						skip_left_ff <= (next_words == 2'h0) ? 2'h0 : next_words - 2'h1;
						state_ff     <= DSJD_SKIP;
						nop_ff       <= 1'b1;
					end else begin
						pc_ff  <= pc_ff + 21'h2;
						nop_ff <= 1'b0;
					end
				end
				DSJD_SKIP: begin
					pc_ff <= pc_ff + 21'h2;
					if (skip_left_ff == 2'h0) begin
						state_ff <= DSJD_EXEC;
						nop_ff   <= 1'b0;
					end else begin
						skip_left_ff <= skip_left_ff - 2'h1;
					end
				end
				DSJD_JMPNOP: begin
					pc_ff    <= pc_ff + 21'h2;
					state_ff <= DSJD_EXEC;
					nop_ff   <= 1'b0;
				end
				default: begin
					state_ff <= DSJD_EXEC;
					nop_ff   <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			quarter_ff <= 2'h0;
		else
			quarter_ff <= quarter;
	end

	assign rf_addr     = rf_addr_ff;
	assign rf_rd       = rf_rd_ff;
	assign rf_wr       = rf_wr_ff;
	assign rf_wdata    = rf_wdata_ff;
	assign wreg        = wreg_ff;
	assign pc          = pc_ff;
	assign nop_cycle   = nop_ff;
	assign quarter_out = quarter_ff;

	// The decrement's own write shows in the first clock of the no-op cycle, so skip it.
	a_nop_no_write: assert property (@(posedge clk) disable iff (reset)
		(nop_ff && $past(nop_ff)) |-> !rf_wr_ff && $stable(wreg_ff))
		else $error("register written during no-op cycle");

	a_jump_two_cyc: assert property (@(posedge clk) disable iff (reset)
		(state_ff == DSJD_JMPNOP && $changed(state_ff)) |-> ##4 state_ff == DSJD_EXEC)
		else $error("jump refill not exactly one cycle");

	a_jump_pc_even: assert property (@(posedge clk) disable iff (reset)
		pc_ff[0] == 1'b0)
		else $error("program counter bit zero set");

	sequence s_dest_w;
		executing && op_ff == DSJD_OP_DNZ && quarter == DSJD_Q4 && !word_ff[`DSJD_BIT_DEST];
	endsequence
	a_dest_wreg: assert property (@(posedge clk) disable iff (reset)
		s_dest_w |=> wreg_ff == $past(result_ff) && !rf_wr_ff)
		else $error("working register not loaded");

	a_skip_nonzero: assert property (@(posedge clk) disable iff (reset)
		(executing && last_q && op_ff == DSJD_OP_DNZ && result_ff != 8'h00) |=> nop_ff)
		else $error("nonzero result did not skip");

	a_skip_zero: assert property (@(posedge clk) disable iff (reset)
		(executing && last_q && op_ff == DSJD_OP_DZ && result_ff == 8'h00) |=> nop_ff)
		else $error("zero result did not skip");

	a_read_q2: assert property (@(posedge clk) disable iff (reset)
		rf_rd_ff |-> quarter == DSJD_Q2)
		else $error("register read outside second quarter");

	a_bank_sel: assert property (@(posedge clk) disable iff (reset)
		(rf_rd_ff && word_ff[`DSJD_BIT_BANK]) |-> rf_addr_ff == ADDR_W'({bank_sel, fa}))
		else $error("bank select not applied");
endmodule
`default_nettype wire

// ### bench/dsjd_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
// Data register file on the far side of the core.
// Read data is inverted outside a read, so a late sample never sees a stale match.
module dsjd_ram_model #(
	parameter int unsigned ADDR_W = 12
) (
	input  wire logic              clk,      // Core clock.
	input  wire logic [ADDR_W-1:0] rf_addr,  // Register address.
	input  wire logic              rf_rd,    // Read strobe.
	input  wire logic              rf_wr,    // Write strobe.
	input  wire logic [7:0]        rf_wdata, // Write data.
	output logic      [7:0]        rf_rdata  // Read data.
);
	logic [7:0] mem [2**ADDR_W];
	logic [7:0] last_ff = 8'hA5;
	always @(posedge clk) begin
		if (rf_wr)
			mem[rf_addr] <= rf_wdata;
		if (rf_rd)
			last_ff <= mem[rf_addr];
	end
	assign rf_rdata = rf_rd ? mem[rf_addr] : ~last_ff;
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int unsigned AW = 12;
	logic          clk, reset, ext_set_en, rf_rd, rf_wr, nop_cycle;
	logic [15:0]   instr_word;
	logic [1:0]    next_words, qo;
	logic [3:0]    bank_sel;
	logic [AW-1:0] idx_base, rf_addr;
	logic [7:0]    rf_rdata, rf_wdata, wreg, wreg_seen, wreg_exp;
	logic [20:0]   pc;
	logic [20:0]   exp_q[$];
	logic [31:0]   seed;
	int            err_total, tests_run, nop_seen, nop_exp;

	dsjd_core #(.ADDR_W(AW)) dsjd_core_inst (.clk(clk), .reset(reset),
		.instr_word(instr_word), .next_words(next_words), .ext_set_en(ext_set_en),
		.bank_sel(bank_sel), .idx_base(idx_base), .rf_rdata(rf_rdata), .rf_addr(rf_addr),
		.rf_rd(rf_rd), .rf_wr(rf_wr), .rf_wdata(rf_wdata), .wreg(wreg), .pc(pc),
		.nop_cycle(nop_cycle), .quarter_out(qo));
	dsjd_ram_model #(.ADDR_W(AW)) dsjd_ram_model_inst (.clk(clk), .rf_addr(rf_addr),
		.rf_rd(rf_rd), .rf_wr(rf_wr), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// One instruction cycle: first word before Q1, second word held through Q4.
	task automatic exec(input logic [15:0] w, input logic [15:0] w2, input logic [1:0] nw);
		instr_word = w;
		next_words = nw;
		@(negedge clk);
		instr_word = w2;
		repeat (3) @(negedge clk);
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#20000;
		err_total++;
		wrap_up();
	end

	// Sampled before the design's updates land, so the count is race free.
	always @(posedge clk) begin
		if (!reset && nop_cycle === 1'b1)
			nop_seen++;
	end

	// Any write with no pending note is a mismatch, which catches writes in no-op cycles.
	always @(negedge clk) begin
		if (!reset && rf_wr === 1'b1)
			check({11'h0, 1'b1, rf_addr, rf_wdata}, exp_q.size() ? exp_q.pop_front() : '1);
		if (!reset && wreg !== wreg_seen)
			check({24'h0, wreg}, exp_q.size() ? exp_q.pop_front() : '1);
		wreg_seen = wreg;
	end

	initial begin
		logic [31:0]   r;
		logic [7:0]    f, v, res;
		logic [AW-1:0] addr;
		logic          d, a, dsnz, skip;
		logic [19:0]   k;
		int            n;
		int            idle;
		{reset, instr_word, next_words, ext_set_en, bank_sel, idx_base} = '0;
		reset = 1'b1;
		seed = 29;
		wreg_exp = 8'h00;
		idle = 0;
		repeat (5) @(negedge clk);
		reset = 1'b0;
		for (int i = 0; i < 60; i++) begin
			r = xs();
			{dsnz, d, a, ext_set_en, bank_sel} = r[7:0];
			f = r[15:8];
			idx_base = r[31:20];
			v = (r[17:16] == 2'h0) ? 8'h01 : 8'(xs());
			if (a)
				addr = {bank_sel, f};
			else if (ext_set_en && f <= 8'h5F)
				addr = idx_base + AW'(f);
			else
				addr = {{4{f[7]}}, f};
			// A write still pending to the same address would overwrite the preset value.
			if (rf_wr === 1'b1 && rf_addr == addr) begin
				exec(16'h0000, 16'h0000, 2'h1);
				idle++;
			end
			dsjd_ram_model_inst.mem[addr] = v;
			res = v - 8'h01;
			if (!d && res == wreg_exp)
				d = 1'b1;
			if (d) begin
				exp_q.push_back({1'b1, addr, res});
			end else begin
				exp_q.push_back({13'h0, res});
				wreg_exp = res;
			end
			skip = dsnz ? (res != 8'h00) : (res == 8'h00);
			n = skip ? ((r[19:18] == 2'h0) ? 1 : int'(r[19:18])) : 0;
			nop_exp += 4 * n;
			exec({dsnz ? 6'h13 : 6'h0B, d, a, f}, 16'(xs()), r[19:18]);
			repeat (n) exec(16'(xs()), 16'(xs()), 2'(xs()));
		end
		check({11'h0, pc}, 32'(2 * (60 + idle + nop_exp / 4)));
		for (int j = 0; j < 4; j++) begin
			k = (j == 0) ? 20'hFFFFF : 20'(xs());
			exec({8'hEF, k[7:0]}, {4'hF, k[19:8]}, 2'h1);
			check({30'h0, qo}, 32'h3);
			instr_word = 16'(xs());
			@(negedge clk);
			check({11'h0, pc}, {11'h0, k, 1'b0});
			check({31'h0, nop_cycle}, 32'h1);
			repeat (3) @(negedge clk);
			nop_exp += 4;
		end
		exec(16'h0000, 16'h0000, 2'h1);
		exec(16'h0000, 16'h0000, 2'h1);
		check({11'h0, pc}, {11'h0, k, 1'b0} + 32'h6);
		check(nop_seen, nop_exp);
		check(exp_q.size(), 0);
		wrap_up();
	end
endmodule
`default_nettype wire
